// ### rtl/tmrfc_timer.sv
// Timer with compare and overflow flags and fast peripheral clock control
// What this block does
// R1 - Compare matches set flag bits 6 and 5
// R2 - Interrupt vector execution clears its flag
// R3 - Writing one clears flag one cycle later
// R4 - Compare requests need global, enable, flag
// R5 - Normal mode: overflow sets bit 2
// R6 - PWM mode: top match sets overflow
// R7 - Overflow request needs global, enable, flag
// R8 - Reserved flag and clock bits read zero
// R9 - Fast clock full rate, halved by select except in compatibility mode
// R10 - Low speed refused while PLL clocks system
// R11 - Software stops counter before low speed change
// R12 - Fast select picks fast clock source
// R13 - Fast select settable only with PLL enabled
// R14 - PLL enable starts PLL, reads forced one while PLL clocks system
// R15 - Software waits lock before using fast clock
// R16 - Compatibility mode only on fuse code 0011
// R17 - Compatibility: two prescalers, synchronous counting
// R18 - Compatibility clock choices fast or system divided
// R19 - Control reads immediate, counter and flags lag
// R20 - Compare A drives pin, top clears
// R21 - Overflow on FF wrap or top wrap
// R22 - PWM counts to top, A match drives pin to BIT_COM_LO level when BIT_COM_HI set, else pin held low
// R23 - PWM enable restarts counter after top
// R24 - Writing zero leaves a flag unchanged
`timescale 1ns/100ps
module tmrfc_timer #(
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // AHB-Lite slave
    input wire tmrfc_pkg::tmrfc_ahb_req_t ahb_req,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Processor side
    input wire logic global_irq_enable,
    input wire tmrfc_pkg::tmrfc_irq_t irq_ack,
    output tmrfc_pkg::tmrfc_irq_t irq_req,
    // Pins from the PLL and fuses
    input wire logic fast_peripheral_clock,
    input wire logic pll_locked,
    input wire logic pll_is_system_clock,
    input wire logic [3:0] clock_select_fuses,
    // Outputs
    output logic pll_start,
    output logic low_speed_select,
    output logic compare_a_output
);
    import tmrfc_pkg::*;

    initial begin
        if (ADDR_W < 8 || ADDR_W > 32) begin
            $error("ADDR_W must lie between 8 and 32");
        end
    end

    typedef struct packed {
        tmrfc_bus_t bus;
        logic [5:0] dp_idx;
        logic [31:0] rdata;
        logic [7:0] ctrl;
        logic [7:0] gctrl;
        logic [7:0] cnt;
        logic [7:0] cnt_rd;
        logic [7:0] cmp_a_buf;
        logic [7:0] cmp_a;
        logic [7:0] cmp_b;
        logic [7:0] top;
        logic [7:0] mask;
        logic low_speed;
        logic fast_sel;
        logic pll_start;
        logic [2:0] flags;
        logic [2:0] clr_pend;
        logic [2:0] evt_pend;
        logic cnt_wr_pend;
        logic [7:0] cnt_wr_val;
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
        logic half;
        logic [PRE_W-1:0] pre_sys;
        logic [PRE_W-1:0] pre_fast;
        logic compat;
        logic fuse_taken;
        logic oc_a;
    } tmrfc_state_t;

    tmrfc_state_t st_r;
    tmrfc_state_t st_nxt;

    // Prescaler tap: source tick divided by two to the power (sel - 1)
    function automatic logic div_tick(input logic [3:0] sel, input logic [PRE_W-1:0] pre,
                                      input logic src);
        logic [PRE_W-1:0] msk;
        msk = (PRE_W'(1) << (sel - 4'h1)) - PRE_W'(1);
        div_tick = src && (sel != 4'h0) && ((pre & msk) == msk);
    endfunction

    // Output pin action for a match in non-PWM operation
    function automatic logic pin_action(input logic [1:0] com, input logic cur);
        case (com)
            2'b01: pin_action = ~cur;
            2'b10: pin_action = 1'b0;
            2'b11: pin_action = 1'b1;
            default: pin_action = cur;
        endcase
    endfunction

    logic addr_take;
    logic [5:0] addr_idx;
    logic [31:0] rd_val;
    logic [7:0] wd;
    logic pwm_mode;
    logic fast_edge;
    logic fast_tick;
    logic cnt_tick;
    logic [3:0] cs;
    logic [7:0] cnt_next;
    logic [2:0] evt;
    logic [2:0] ack;
    logic wr_fired;

    assign addr_idx = ahb_req.haddr[7:2];
    assign addr_take = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;
    assign wd = ahb_req.hwdata[7:0];
    assign pwm_mode = st_r.ctrl[BIT_PWM_A] || st_r.gctrl[BIT_PWM_B];
    assign cs = st_r.ctrl[3:0];
    assign ack = {irq_ack.compare_a, irq_ack.compare_b, irq_ack.overflow};
    assign wr_fired = (st_r.bus == BUS_WRITE);
    // Fast edge accepted once the second and third stages agree
    assign fast_edge = (st_r.s2[PIN_FAST] == st_r.s3[PIN_FAST]) && st_r.s3[PIN_FAST]
                       && !st_r.lvl[PIN_FAST];
    // R9 halved fast clock
    assign fast_tick = fast_edge && (!st_r.low_speed || st_r.compat || st_r.half);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (st_r.dp_idx)
            // R8 reserved bits zero
            IDX_FLAGS: rd_val[7:0] = {1'b0, st_r.flags[EV_A], st_r.flags[EV_B], 2'b00,
                                       st_r.flags[EV_OVF], 2'b00};
            // R14 forced enable readback
            IDX_PLL_CTRL: rd_val[7:0] = {st_r.low_speed, 4'h0, st_r.fast_sel,
                                          st_r.pll_start || st_r.lvl[PIN_SYSPLL],
                                          st_r.lvl[PIN_LOCK]};
            // R19 immediate control readback
            IDX_CTRL: rd_val[7:0] = st_r.ctrl;
            IDX_GEN_CTRL: rd_val[7:0] = {st_r.gctrl[7:4], 4'h0};
            IDX_CMP_A: rd_val[7:0] = st_r.cmp_a_buf;
            IDX_CMP_B: rd_val[7:0] = st_r.cmp_b;
            IDX_TOP: rd_val[7:0] = st_r.top;
            IDX_MASK: rd_val[7:0] = st_r.mask & 8'h64;
            // R19 lagging counter readback
            IDX_COUNT: rd_val[7:0] = st_r.cnt_rd;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_comb begin
        if (st_r.compat) begin
            // R17 synchronous compat clocking
            if (cs >= CS_FIRST_SYS) begin
                // R18 system clock divided
                cnt_tick = div_tick(cs - CS_COMPAT_OFS, st_r.pre_sys, 1'b1);
            end else begin
                // R18 fast clock divided
                cnt_tick = div_tick(cs, st_r.pre_fast, fast_tick);
            end
        end else if (st_r.fast_sel) begin
            // R12 fast clock source
            cnt_tick = div_tick(cs, st_r.pre_fast, fast_tick);
        end else begin
            // R12 system clock source
            cnt_tick = div_tick(cs, st_r.pre_sys, 1'b1);
        end
    end

    always_comb begin
        st_nxt = st_r;
        evt = 3'b000;
        cnt_next = st_r.cnt;
        // Three stage pin synchronisers
        st_nxt.s1 = {pll_is_system_clock, pll_locked, fast_peripheral_clock};
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 3; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.lvl[i] = st_r.s3[i];
            end
        end
        if (fast_edge) begin
            st_nxt.half = ~st_r.half;
            st_nxt.pre_fast = st_r.pre_fast + PRE_W'(1);
        end
        st_nxt.pre_sys = st_r.pre_sys + PRE_W'(1);
        // R16 fuse code caught after reset
        if (!st_r.fuse_taken) begin
            st_nxt.fuse_taken = 1'b1;
            st_nxt.compat = (clock_select_fuses == FUSE_COMPAT);
        end
        st_nxt.cnt_rd = st_r.cnt;
        // Bus phases
        case (st_r.bus)
            BUS_READ_WAIT: begin
                st_nxt.rdata = rd_val;
                st_nxt.bus = BUS_READ_DONE;
            end
            default: begin
                st_nxt.bus = BUS_IDLE;
                if (addr_take) begin
                    st_nxt.dp_idx = addr_idx;
                    // Shift keeps the check legal when the bus is only 8 bits wide
                    if ((ahb_req.haddr[ADDR_W-1:0] >> 8) != '0) begin
                        st_nxt.dp_idx = 6'h00;
                    end
                    st_nxt.bus = ahb_req.hwrite ? BUS_WRITE : BUS_READ_WAIT;
                end
            end
        endcase
        // Flags clear one cycle after the write; set wins
        // R2 vector clears flag
        // R3 delayed write clear
        st_nxt.flags = (st_r.flags & ~(st_r.clr_pend | ack)) | st_r.evt_pend;
        st_nxt.clr_pend = 3'b000;
        // Counter: software write lands a cycle late and never matches
        if (st_r.cnt_wr_pend) begin
            st_nxt.cnt = st_r.cnt_wr_val;
            st_nxt.cnt_wr_pend = 1'b0;
        end else if (cnt_tick) begin
            if (pwm_mode && st_r.cnt == st_r.top) begin
                // R23 restart after top
                // R6 top match overflow
                cnt_next = 8'h00;
                evt[EV_OVF] = 1'b1;
                // Compare A buffered value latched at top, avoids glitches
                st_nxt.cmp_a = st_r.cmp_a_buf;
            end else if (st_r.cnt == COUNT_WRAP) begin
                // R5 natural overflow
                // R21 wrap to zero
                cnt_next = 8'h00;
                evt[EV_OVF] = 1'b1;
            end else if (!pwm_mode && st_r.ctrl[BIT_CLEAR_ON_TOP] && st_r.cnt == st_r.top) begin
                // R20 top clears counter
                cnt_next = 8'h00;
            end else begin
                // R22 counting up
                cnt_next = st_r.cnt + 8'h01;
            end
            st_nxt.cnt = cnt_next;
            // R1 compare matches
            evt[EV_A] = (cnt_next == st_r.cmp_a);
            evt[EV_B] = (cnt_next == st_r.cmp_b);
            // R20 compare A pin action
            if (st_r.ctrl[BIT_PWM_A]) begin
                // R22 PWM output transitions
                if (evt[EV_A]) begin
                    st_nxt.oc_a = st_r.ctrl[BIT_COM_LO];
                end else if (cnt_next == COUNT_ONE) begin
                    st_nxt.oc_a = ~st_r.ctrl[BIT_COM_LO];
                end
                if (!st_r.ctrl[BIT_COM_HI]) begin
                    st_nxt.oc_a = 1'b0;
                end
            end else if (evt[EV_A]) begin
                st_nxt.oc_a = pin_action(st_r.ctrl[5:4], st_r.oc_a);
            end
        end
        // Events pass one sync stage before reaching the flags
        st_nxt.evt_pend = evt;
        // Register writes in the data phase
        if (wr_fired) begin
            case (st_r.dp_idx)
                IDX_FLAGS: begin
                    // R24 zero bits ignored
                    st_nxt.clr_pend = {wd[BIT_CMP_A], wd[BIT_CMP_B], wd[BIT_OVF]};
                end
                IDX_PLL_CTRL: begin
                    // R10 low speed refused
                    st_nxt.low_speed = wd[BIT_LOW_SPEED] && !st_r.lvl[PIN_SYSPLL];
                    // R13 needs PLL already enabled
                    st_nxt.fast_sel = wd[BIT_FAST_SEL] && st_r.pll_start;
                    // R14 PLL start
                    st_nxt.pll_start = wd[BIT_PLL_START];
                end
                IDX_CTRL: st_nxt.ctrl = wd;
                IDX_GEN_CTRL: begin
                    st_nxt.gctrl = {wd[7:4], 4'h0};
                    if (wd[BIT_PRE_RESET]) begin
                        st_nxt.pre_sys = '0;
                        st_nxt.pre_fast = '0;
                    end
                    if (wd[BIT_FORCE_A] && !st_r.ctrl[BIT_PWM_A]) begin
                        st_nxt.oc_a = pin_action(st_r.ctrl[5:4], st_r.oc_a);
                    end
                end
                IDX_COUNT: begin
                    st_nxt.cnt_wr_pend = 1'b1;
                    st_nxt.cnt_wr_val = wd;
                end
                IDX_CMP_A: begin
                    st_nxt.cmp_a_buf = wd;
                    if (!st_r.ctrl[BIT_PWM_A]) begin
                        st_nxt.cmp_a = wd;
                    end
                end
                IDX_CMP_B: st_nxt.cmp_b = wd;
                IDX_TOP: st_nxt.top = wd;
                IDX_MASK: st_nxt.mask = wd & 8'h64;
                default: st_nxt.ctrl = st_r.ctrl;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= '0;
            st_r.top <= COUNT_WRAP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign hreadyout = (st_r.bus != BUS_READ_WAIT);
    assign hresp = 1'b0;
    assign hrdata = st_r.rdata;
    // R4 compare requests
    assign irq_req.compare_a = global_irq_enable && st_r.mask[BIT_CMP_A] && st_r.flags[EV_A];
    assign irq_req.compare_b = global_irq_enable && st_r.mask[BIT_CMP_B] && st_r.flags[EV_B];
    // R7 overflow request
    assign irq_req.overflow = global_irq_enable && st_r.mask[BIT_OVF] && st_r.flags[EV_OVF];
    assign pll_start = st_r.pll_start;
    assign low_speed_select = st_r.low_speed;
    assign compare_a_output = st_r.oc_a;
endmodule

// ### rtl/tmrfc_pkg.sv
// Register map, field positions and carrier types of the timer and fast clock block
package tmrfc_pkg;
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_PLL_CTRL = 6'h27;
    localparam logic [5:0] IDX_FLAGS = 6'h38;
    localparam logic [5:0] IDX_GEN_CTRL = 6'h2C;
    localparam logic [5:0] IDX_CTRL = 6'h30;
    localparam logic [5:0] IDX_COUNT = 6'h2F;
    localparam logic [5:0] IDX_CMP_A = 6'h2E;
    localparam logic [5:0] IDX_TOP = 6'h2D;
    localparam logic [5:0] IDX_CMP_B = 6'h2B;
    localparam logic [5:0] IDX_MASK = 6'h39;
    // Flag and mask bit positions
    localparam int BIT_CMP_A = 6;
    localparam int BIT_CMP_B = 5;
    localparam int BIT_OVF = 2;
    // Clock control bit positions
    localparam int BIT_LOW_SPEED = 7;
    localparam int BIT_FAST_SEL = 2;
    localparam int BIT_PLL_START = 1;
    localparam int BIT_LOCK = 0;
    // Counter control bit positions
    localparam int BIT_CLEAR_ON_TOP = 7;
    localparam int BIT_PWM_A = 6;
    localparam int BIT_COM_HI = 5;
    localparam int BIT_COM_LO = 4;
    // General control bit positions
    localparam int BIT_PWM_B = 6;
    localparam int BIT_FORCE_B = 3;
    localparam int BIT_FORCE_A = 2;
    localparam int BIT_PRE_RESET = 1;
    // Event vector positions inside the three-flag group
    localparam int EV_A = 2;
    localparam int EV_B = 1;
    localparam int EV_OVF = 0;
    // Synchronised pin positions
    localparam int PIN_FAST = 0;
    localparam int PIN_LOCK = 1;
    localparam int PIN_SYSPLL = 2;
    // Reset values and fixed codes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] COUNT_WRAP = 8'hFF;
    localparam logic [7:0] COUNT_ONE = 8'h01;
    localparam logic [3:0] FUSE_COMPAT = 4'h3;
    localparam logic [3:0] CS_FIRST_SYS = 4'h5;
    localparam logic [3:0] CS_COMPAT_OFS = 4'h4;
    localparam int PRE_W = 14;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WRITE = 2'b01,
        BUS_READ_WAIT = 2'b10,
        BUS_READ_DONE = 2'b11
    } tmrfc_bus_t;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } tmrfc_ahb_req_t;

    typedef struct packed {
        logic compare_a;
        logic compare_b;
        logic overflow;
    } tmrfc_irq_t;
endpackage

// ### test/tmrfc_timer_asserts.sv
// Bus, flag and clock control assertions for the timer block
`timescale 1ns/100ps
module tmrfc_timer_asserts
    import tmrfc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Bus
    input wire tmrfc_pkg::tmrfc_ahb_req_t ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Interrupts
    input wire logic global_irq_enable,
    input wire tmrfc_pkg::tmrfc_irq_t irq_req,
    // Clock pins
    input wire logic pll_locked,
    input wire logic pll_is_system_clock,
    input wire logic low_speed_select
);
    wire logic rd_go = ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & !ahb_req.hwrite;
    wire logic rd_pll = rd_go && (ahb_req.haddr[7:2] == IDX_PLL_CTRL);

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    rd_wait_a: assert property (rd_go |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    okay_resp_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    flag_resv_a: assert property (
        rd_go && ahb_req.haddr[7:2] == IDX_FLAGS |-> ##2 !hrdata[7] && !hrdata[0])
        else $error("reserved flag bits set");
    pll_resv_a: assert property (rd_pll |-> ##2 hrdata[6:3] == 4'h0)
        else $error("reserved clock bits set");
    pll_forced_a: assert property (pll_is_system_clock[*6] ##0 rd_pll |-> ##2 hrdata[1])
        else $error("pll enable not forced");
    lock_read_a: assert property (pll_locked[*6] ##0 rd_pll |-> ##2 hrdata[0])
        else $error("lock bit not shown");
    low_refuse_a: assert property (pll_is_system_clock[*6] |-> !$rose(low_speed_select))
        else $error("low speed set on pll clock");
    irq_gate_a: assert property (!global_irq_enable |-> irq_req == 3'h0)
        else $error("request without global enable");
endmodule

bind tmrfc_timer tmrfc_timer_asserts chk_i (.core_clk(core_clk), .reset(reset),
    .ahb_req(ahb_req), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_irq_enable(global_irq_enable), .irq_req(irq_req), .pll_locked(pll_locked),
    .pll_is_system_clock(pll_is_system_clock), .low_speed_select(low_speed_select));

// ### test/tmrfc_timer_tb_top.sv
// Self-checking testbench for the timer block
`timescale 1ns/100ps
module tmrfc_timer_tb_top;
    import tmrfc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    tmrfc_ahb_req_t req_r = '0;
    tmrfc_ahb_req_t ahb_req;
    tmrfc_irq_t ack = '0;
    tmrfc_irq_t irq;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic glb_en = 1'b0;
    logic locked = 1'b0;
    logic sys_pll = 1'b0;
    logic pll_start;
    logic low_speed;
    logic cmp_out;
    logic [7:0] d;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Register index, write value, expected read
    localparam logic [21:0] ROWS [12] = '{
        {IDX_CTRL, 8'hB0, 8'hB0}, {IDX_GEN_CTRL, 8'h3F, 8'h30},
        {IDX_CMP_A, 8'h5A, 8'h5A}, {IDX_TOP, 8'hC3, 8'hC3},
        {IDX_CMP_B, 8'h81, 8'h81}, {IDX_MASK, 8'hFF, 8'h64},
        {6'h3F, 8'hFF, 8'h00}, {IDX_FLAGS, 8'hFF, 8'h00},
        {IDX_PLL_CTRL, 8'hFC, 8'h80}, {IDX_PLL_CTRL, 8'h02, 8'h02},
        {IDX_PLL_CTRL, 8'h06, 8'h06}, {IDX_PLL_CTRL, 8'h00, 8'h00}};

    always #5 core_clk = ~core_clk;

    // Single slave, so its ready is the bus ready
    always_comb begin
        ahb_req = req_r;
        ahb_req.hready = hreadyout;
    end

    tmrfc_timer dut (.core_clk(core_clk), .reset(reset), .ahb_req(ahb_req),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .global_irq_enable(glb_en),
        .irq_ack(ack), .irq_req(irq), .fast_peripheral_clock(1'b0), .pll_locked(locked),
        .pll_is_system_clock(sys_pll), .clock_select_fuses(4'h0), .pll_start(pll_start),
        .low_speed_select(low_speed), .compare_a_output(cmp_out));

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic clk(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Ready is looked at mid-cycle, so it is the value the next rising edge samples
    // Hang on a slow ready is cut by the cycle ceiling
    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        req_r.hsel <= 1'b1;
        req_r.htrans <= 2'h2;
        req_r.hwrite <= wr;
        req_r.hsize <= 3'h2;
        req_r.haddr <= {24'h0, idx, 2'h0};
        do @(negedge core_clk); while (hreadyout !== 1'b1);
        @(posedge core_clk);
        req_r.hsel <= 1'b0;
        req_r.htrans <= 2'h0;
        req_r.hwdata <= {24'h0, wd};
        do @(negedge core_clk); while (hreadyout !== 1'b1);
        d = hrdata[7:0];
        @(posedge core_clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rchk(input string n, input logic [5:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk(n, exp, d);
    endtask

    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        clk(12);
        reset <= 1'b0;
        clk(1);
        foreach (ROWS[i]) begin
            wr(ROWS[i][21:16], ROWS[i][15:8]);
            rchk("register row", ROWS[i][21:16], ROWS[i][7:0]);
        end
        $display("register table done");
        // Second reset mid-run brings back defaults
        reset <= 1'b1;
        clk(3);
        reset <= 1'b0;
        clk(2);
        rchk("top reset", IDX_TOP, 8'hFF);
        rchk("ctrl reset", IDX_CTRL, 8'h00);
        rchk("pll reset", IDX_PLL_CTRL, 8'h00);
        rchk("flags reset", IDX_FLAGS, 8'h00);
        $display("reset test done");
        wr(IDX_MASK, 8'h64);
        glb_en <= 1'b1;
        wr(IDX_CMP_A, 8'h10);
        wr(IDX_COUNT, 8'h00);
        // Select 1 on the system clock steps once per cycle
        wr(IDX_CTRL, 8'h01);
        clk(40);
        wr(IDX_CTRL, 8'h00);
        rchk("compare a flag", IDX_FLAGS, 8'h40);
        chk("irq a", 8'h04, {5'h0, irq});
        wr(IDX_FLAGS, 8'h00);
        rchk("zero write", IDX_FLAGS, 8'h40);
        wr(IDX_FLAGS, 8'h40);
        rchk("one clears", IDX_FLAGS, 8'h00);
        chk("irq a clear", 8'h00, {5'h0, irq});
        $display("compare test done");
        wr(IDX_CMP_A, 8'h80);
        wr(IDX_COUNT, 8'hF0);
        wr(IDX_CTRL, 8'h01);
        clk(24);
        wr(IDX_CTRL, 8'h00);
        rchk("wrap flags", IDX_FLAGS, 8'h24);
        chk("irq b ovf", 8'h03, {5'h0, irq});
        ack.overflow <= 1'b1;
        clk(1);
        ack.overflow <= 1'b0;
        clk(1);
        rchk("ack clears", IDX_FLAGS, 8'h20);
        glb_en <= 1'b0;
        clk(1);
        chk("global off", 8'h00, {5'h0, irq});
        $display("overflow test done");
        wr(IDX_FLAGS, 8'h64);
        wr(IDX_TOP, 8'h20);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CTRL, 8'h41);
        clk(45);
        wr(IDX_CTRL, 8'h00);
        bus(1'b0, IDX_FLAGS, 8'h00);
        chk("top overflow", 8'h04, d & 8'h04);
        bus(1'b0, IDX_COUNT, 8'h00);
        chk("below top", 8'h01, {7'h0, d <= 8'h20});
        $display("pwm test done");
        sys_pll <= 1'b1;
        locked <= 1'b1;
        clk(6);
        wr(IDX_PLL_CTRL, 8'h80);
        rchk("pll as system", IDX_PLL_CTRL, 8'h03);
        sys_pll <= 1'b0;
        clk(6);
        rchk("pll released", IDX_PLL_CTRL, 8'h01);
        $display("pll test done");
        final_report();
    end
endmodule
